// ===== core/ewc_pkg.sv
// package: constants and carrier types for the two-wire bus host
package ewc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS          = 5;
    localparam int unsigned POWER_UP_WAIT_TIME_US  = 100;
    localparam int unsigned POWER_UP_WAIT_CYC      =
        (POWER_UP_WAIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // one quarter of an scl period; low and high phases are two quarters
    localparam int unsigned SCL_QUARTER_TIME_NS    = 2500;
    localparam int unsigned Q_CYC                  =
        (SCL_QUARTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // widths and counts
    // ------------------------------------------------------------------
    localparam int unsigned POR_CNT_W  = 16;
    localparam int unsigned TICK_W     = 10;
    localparam int unsigned BYTE_BITS  = 8;
    localparam int unsigned RECOV_MAX  = 9;
    localparam logic [3:0]  ACK_SLOT   = 4'h8;
    localparam logic [3:0]  RECOV_LAST = 4'h8;
    localparam logic [7:0]  BYTE_ONES  = 8'hFF;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP,
        CMD_RECOVER
    } ewc_cmd_kind_t;

    typedef struct packed {
        ewc_cmd_kind_t kind;
        logic [7:0]    data;
        logic          nack;
    } ewc_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       ack;
        logic       err;
    } ewc_rsp_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_IDLE,
        ST_START,
        ST_BIT,
        ST_STOP,
        ST_RECOV,
        ST_RESP
    } ewc_state_t;

endpackage : ewc_pkg

// ===== core/ewc_host.sv
// module: bit-level two-wire bus host for a serial eeprom
`timescale 1ns/1ps
`default_nettype none

module ewc_host
    import ewc_pkg::*;
#(
    parameter int unsigned POWER_UP_WAIT_CYCLES = POWER_UP_WAIT_CYC
) (
    // clock and reset
    input  wire logic     i_core_clk,
    input  wire logic     i_reset_n,
    // command port
    input  wire logic     i_cmd_valid,
    input  wire ewc_cmd_t i_cmd,
    output logic          o_cmd_ready,
    // response port
    output logic          o_rsp_valid,
    output var ewc_rsp_t  o_rsp,
    // bus pins
    output logic          o_scl,
    input  wire logic     i_scl,
    input  wire logic     i_sda,
    output logic          o_sda,
    output logic          o_sda_oe_n
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic scl_meta_reg, scl_s_reg, sda_meta_reg, sda_s_reg;
    logic scl_meta_next, scl_s_next, sda_meta_next, sda_s_next;

    always_comb begin
        scl_meta_next = i_scl;
        scl_s_next    = scl_meta_reg;
        sda_meta_next = i_sda;
        sda_s_next    = sda_meta_reg;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scl_meta_reg <= 1'b1;
            scl_s_reg    <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_s_reg    <= 1'b1;
        end else begin
            scl_meta_reg <= scl_meta_next;
            scl_s_reg    <= scl_s_next;
            sda_meta_reg <= sda_meta_next;
            sda_s_reg    <= sda_s_next;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    ewc_state_t          state_reg, state_next;
    ewc_cmd_kind_t       kind_reg, kind_next;
    logic [1:0]          q_reg, q_next;
    logic [TICK_W-1:0]   tick_reg, tick_next;
    logic [POR_CNT_W-1:0] por_reg, por_next;
    logic [3:0]          bit_reg, bit_next;
    logic [3:0]          pulse_reg, pulse_next;
    logic [7:0]          shift_reg, shift_next;
    logic [7:0]          rx_reg, rx_next;
    logic                ack_reg, ack_next;
    logic                err_reg, err_next;
    logic                owned_reg, owned_next;
    logic                nack_reg, nack_next;
    logic                scl_reg, scl_next;
    logic                oe_n_reg, oe_n_next;
    logic                ready_reg, ready_next;
    logic                rsp_v_reg, rsp_v_next;
    logic                step;

    // level put on sda for a slot; released means logic one
    function automatic logic sda_level(input logic [3:0] idx,
                                       input logic       rd,
                                       input logic [7:0] tx,
                                       input logic       nk);
        if (idx < ACK_SLOT)
            sda_level = rd ? 1'b1 : tx[3'(BYTE_BITS - 1) - idx[2:0]];
        else
            sda_level = rd ? nk : 1'b1;
    endfunction

    always_comb begin
        state_next = state_reg;
        kind_next  = kind_reg;
        q_next     = q_reg;
        tick_next  = tick_reg;
        por_next   = por_reg;
        bit_next   = bit_reg;
        pulse_next = pulse_reg;
        shift_next = shift_reg;
        rx_next    = rx_reg;
        ack_next   = ack_reg;
        err_next   = err_reg;
        owned_next = owned_reg;
        nack_next  = nack_reg;
        scl_next   = scl_reg;
        oe_n_next  = oe_n_reg;
        step       = (tick_reg == TICK_W'(Q_CYC - 1));
        if (state_reg inside {ST_START, ST_BIT, ST_STOP, ST_RECOV}) begin
            // one pause only, the fresh-start wait in quarter 0; every other quarter lasts the same count
            if (step) begin
                tick_next = '0;
                q_next    = q_reg + 2'd1;
            end else begin
                tick_next = tick_reg + 1'b1;
            end
        end
        unique case (state_reg)
            ST_POR: begin
                if (por_reg == POR_CNT_W'(POWER_UP_WAIT_CYCLES - 1))
                    state_next = ST_IDLE;
                else
                    por_next = por_reg + 1'b1;
            end
            ST_IDLE: begin
                if (i_cmd_valid && ready_reg) begin
                    kind_next = i_cmd.kind;
                    err_next  = 1'b0;
                    ack_next  = 1'b0;
                    tick_next = '0;
                    q_next    = '0;
                    unique case (i_cmd.kind)
                        CMD_START: begin
                            state_next = ST_START;
                            oe_n_next  = 1'b1;
                        end
                        CMD_WRITE, CMD_READ: begin
                            // bytes only inside a transfer opened by start
                            if (!owned_reg) begin
                                err_next   = 1'b1;
                                state_next = ST_RESP;
                            end else begin
                                shift_next = (i_cmd.kind == CMD_READ) ?
                                             BYTE_ONES : i_cmd.data;
                                nack_next  = i_cmd.nack;
                                bit_next   = '0;
                                state_next = ST_BIT;
                                oe_n_next  = sda_level(4'h0,
                                    i_cmd.kind == CMD_READ, i_cmd.data,
                                    i_cmd.nack);
                            end
                        end
                        CMD_STOP: begin
                            if (!owned_reg) begin
                                err_next   = 1'b1;
                                state_next = ST_RESP;
                            end else begin
                                state_next = ST_STOP;
                                oe_n_next  = 1'b0;
                            end
                        end
                        CMD_RECOVER: begin
                            state_next = ST_RECOV;
                            oe_n_next  = 1'b1;
                            scl_next   = 1'b0;
                            pulse_next = '0;
                            owned_next = 1'b0;
                        end
                        // undefined codes are answered, never driven
                        default: begin
                            err_next   = 1'b1;
                            state_next = ST_RESP;
                        end
                    endcase
                end
            end
            ST_START: begin
                // a fresh start waits for both lines high
                if (q_reg == 2'd0 && !owned_reg
                    && !(scl_s_reg && sda_s_reg)) begin
                    // hold the quarter too, not just the count
                    tick_next = '0;
                    q_next    = q_reg;
                end else if (step && q_reg == 2'd0)
                    scl_next = 1'b1;
                else if (step && q_reg == 2'd1)
                    oe_n_next = 1'b0;
                else if (step && q_reg == 2'd3) begin
                    scl_next   = 1'b0;
                    owned_next = 1'b1;
                    ack_next   = 1'b1;
                    state_next = ST_RESP;
                end
            end
            ST_BIT: begin
                if (step && q_reg == 2'd1)
                    scl_next = 1'b1;
                else if (step && q_reg == 2'd2) begin
                    // sample mid-high, well clear of both edges
                    if (bit_reg < ACK_SLOT) begin
                        if (kind_reg == CMD_READ)
                            rx_next = {rx_reg[6:0], sda_s_reg};
                    end else begin
                        ack_next = !sda_s_reg;
                    end
                end else if (step && q_reg == 2'd3) begin
                    scl_next = 1'b0;
                    if (bit_reg == ACK_SLOT) begin
                        oe_n_next  = 1'b1;
                        state_next = ST_RESP;
                    end else begin
                        bit_next  = bit_reg + 4'd1;
                        oe_n_next = sda_level(bit_reg + 4'd1,
                            kind_reg == CMD_READ, shift_reg,
                            nack_reg);
                    end
                end
            end
            ST_STOP: begin
                if (step && q_reg == 2'd0)
                    scl_next = 1'b1;
                else if (step && q_reg == 2'd1)
                    oe_n_next = 1'b1;
                else if (step && q_reg == 2'd3) begin
                    owned_next = 1'b0;
                    ack_next   = 1'b1;
                    state_next = ST_RESP;
                end
            end
            ST_RECOV: begin
                if (step && q_reg == 2'd1)
                    scl_next = 1'b1;
                else if (step && q_reg == 2'd2) begin
                    if (sda_s_reg || pulse_reg == RECOV_LAST) begin
                        ack_next   = sda_s_reg;
                        state_next = ST_RESP;
                    end
                end else if (step && q_reg == 2'd3) begin
                    scl_next   = 1'b0;
                    pulse_next = pulse_reg + 4'd1;
                end
            end
            ST_RESP: begin
                state_next = ST_IDLE;
            end
        endcase
        ready_next = (state_next == ST_IDLE);
        rsp_v_next = (state_next == ST_RESP);
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_POR;
            kind_reg  <= CMD_START;
            q_reg     <= '0;
            tick_reg  <= '0;
            por_reg   <= '0;
            bit_reg   <= '0;
            pulse_reg <= '0;
            shift_reg <= '0;
            rx_reg    <= '0;
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            owned_reg <= 1'b0;
            nack_reg  <= 1'b0;
            scl_reg   <= 1'b1;
            oe_n_reg  <= 1'b1;
            ready_reg <= 1'b0;
            rsp_v_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg  <= kind_next;
            q_reg     <= q_next;
            tick_reg  <= tick_next;
            por_reg   <= por_next;
            bit_reg   <= bit_next;
            pulse_reg <= pulse_next;
            shift_reg <= shift_next;
            rx_reg    <= rx_next;
            ack_reg   <= ack_next;
            err_reg   <= err_next;
            owned_reg <= owned_next;
            nack_reg  <= nack_next;
            scl_reg   <= scl_next;
            oe_n_reg  <= oe_n_next;
            ready_reg <= ready_next;
            rsp_v_reg <= rsp_v_next;
        end
    end

    // sda is open drain: the data output is a constant low
    assign o_sda       = 1'b0;
    assign o_sda_oe_n  = oe_n_reg;
    assign o_scl       = scl_reg;
    assign o_cmd_ready = ready_reg;
    assign o_rsp_valid = rsp_v_reg;
    assign o_rsp       = '{data: rx_reg, ack: ack_reg, err: err_reg};

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    localparam int HIGH_LEN = 2 * Q_CYC;
    logic [POR_CNT_W-1:0] up_cnt_reg;
    logic [TICK_W:0]      high_cnt_reg;
    logic [3:0]           rise_cnt_reg;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            up_cnt_reg   <= '0;
            high_cnt_reg <= '0;
            rise_cnt_reg <= '0;
        end else begin
            if (up_cnt_reg != '1)
                up_cnt_reg <= up_cnt_reg + 1'b1;
            high_cnt_reg <= scl_reg ? high_cnt_reg + 1'b1 : '0;
            if (state_reg == ST_IDLE)
                rise_cnt_reg <= '0;
            else if (state_reg == ST_BIT && !scl_reg && scl_next)
                rise_cnt_reg <= rise_cnt_reg + 4'd1;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_sda_grab;
        $fell(o_sda_oe_n) && state_reg == ST_START;
    endsequence
    sequence s_bit_hold;
        state_reg == ST_BIT && $past(state_reg) == ST_BIT;
    endsequence

    property p_power_up_wait;
        o_cmd_ready |-> up_cnt_reg >= POR_CNT_W'(POWER_UP_WAIT_CYCLES);
    endproperty
    a_power_up_wait: assert property (p_power_up_wait)
        else $error("command accepted before power-up wait");

    property p_nine_clocks;
        (state_reg == ST_RESP && kind_reg inside {CMD_WRITE, CMD_READ}
            && !err_reg) |-> rise_cnt_reg == 4'd9;
    endproperty
    a_nine_clocks: assert property (p_nine_clocks)
        else $error("byte did not take nine clocks");

    property p_high_len;
        (state_reg == ST_BIT && $fell(o_scl)) |->
            high_cnt_reg == (TICK_W + 1)'(HIGH_LEN);
    endproperty
    a_high_len: assert property (p_high_len)
        else $error("scl high phase length wrong");

    property p_sda_steady;
        (s_bit_hold and (o_scl && $past(o_scl))) |-> $stable(o_sda_oe_n);
    endproperty
    a_sda_steady: assert property (p_sda_steady)
        else $error("sda moved while scl high");

    property p_start_idle;
        (state_reg == ST_START && q_reg == 2'd0 && !owned_reg
            && tick_reg == TICK_W'(1)) |-> $past(scl_s_reg && sda_s_reg);
    endproperty
    a_start_idle: assert property (p_start_idle)
        else $error("start issued on a busy bus");

    property p_start_shape;
        s_sda_grab |-> o_scl ##1 o_scl [*2];
    endproperty
    a_start_shape: assert property (p_start_shape)
        else $error("start not made with scl high");

    property p_ack_release;
        (state_reg == ST_BIT && bit_reg == ACK_SLOT && kind_reg == CMD_WRITE)
            |-> o_sda_oe_n;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("sda held during ack slot of a write");

    property p_ninth_release;
        (state_reg == ST_RESP && kind_reg == CMD_READ) |-> o_sda_oe_n;
    endproperty
    a_ninth_release: assert property (p_ninth_release)
        else $error("sda not released after ninth clock");

    property p_recov_bound;
        state_reg == ST_RECOV |-> pulse_reg < 4'(RECOV_MAX);
    endproperty
    a_recov_bound: assert property (p_recov_bound)
        else $error("recovery ran past nine clocks");

    property p_recov_fresh;
        (state_reg == ST_RESP && kind_reg == CMD_RECOVER) |-> !owned_reg;
    endproperty
    a_recov_fresh: assert property (p_recov_fresh)
        else $error("transfer still open after recovery");

endmodule // ewc_host

`default_nettype wire

// ===== test/ewc_eeprom_model.sv
// file: behavioural serial eeprom client seen from the bus pins
`timescale 1ns/1ps
`default_nettype none

module ewc_eeprom_model
    import ewc_pkg::*;
#(
    parameter logic [2:0]  HW_ADDR = 3'h0,
    // length of the internal write cycle, plain default
    parameter int unsigned WR_NS   = 1000
) (
    // supply and lines
    input  wire logic       i_reset_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    // read data and observation
    input  wire logic [7:0] i_rd_byte,
    output logic            o_sda_oe_n = 1'b1,
    output logic [7:0]      o_rx_byte = 8'h00
);
    logic       active = 1'b0;
    logic       first = 1'b0;
    logic       sending = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [7:0] shift = 8'h00;
    logic [7:0] tx = 8'h00;
    logic       busy = 1'b0;
    logic       wr_seen = 1'b0;

    // ------------------------------------------------------------------
    // start and stop, seen only while scl is high
    // ------------------------------------------------------------------
    always @(negedge i_sda) begin
        // short filter: an sda edge in the step of an scl fall is no start
        #1;
        if (i_scl === 1'b1 && i_sda === 1'b0
            && i_reset_n === 1'b1) begin
            active = 1'b1;
            first = 1'b1;
            sending = 1'b0;
            cnt = 4'h0;
        end
    end
    always @(posedge i_sda) begin
        #1;
        if (i_scl === 1'b1 && i_sda === 1'b1) begin
            active = 1'b0;
            o_sda_oe_n = 1'b1;
            if (wr_seen) begin
                // stops are ignored while the cells are written
                wr_seen = 1'b0;
                busy = 1'b1;
                #(WR_NS);
                busy = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // bits: sampled on scl rise, driven on scl fall
    // ------------------------------------------------------------------
    always @(posedge i_scl) begin
        if (active) begin
            if (cnt < 4'h8)
                shift = {shift[6:0], i_sda};
            else if (sending && i_sda === 1'b1)
                sending = 1'b0;
            cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        end
    end
    always @(negedge i_scl) begin
        if (active && cnt == 4'h8 && !sending) begin
            o_rx_byte = shift;
            // no answer to any address while the write cycle runs
            if (first && (busy || shift[7:1] !== {4'hA, HW_ADDR})) begin
                active = 1'b0;
            end else begin
                o_sda_oe_n = 1'b0;
                wr_seen = wr_seen | !first;
                sending = first & shift[0];
            end
            first = 1'b0;
        end else if (active) begin
            // released in slot nine and when not sending, pulled low only by data
            if (cnt == 4'h0)
                tx = i_rd_byte;
            o_sda_oe_n = (sending && cnt != 4'h8) ? tx[3'h7 - cnt[2:0]] : 1'b1;
        end
    end
endmodule // ewc_eeprom_model

`default_nettype wire

// ===== test/ewc_host_tb.sv
// file: self-checking testbench of the two-wire bus host
`timescale 1ns/1ps
`default_nettype none

module ewc_host_tb;
    import ewc_pkg::*;

    localparam int unsigned PUW   = 20;
    localparam logic [2:0]  HW    = 3'h0;
    localparam ewc_rsp_t    ERR_M = '{8'h00, 1'b0, 1'b1};
    localparam ewc_rsp_t    ACK_M = '{8'h00, 1'b1, 1'b1};
    localparam ewc_rsp_t    ALL_M = '{8'hFF, 1'b1, 1'b1};
    localparam ewc_rsp_t    OK    = '{8'h00, 1'b1, 1'b0};
    localparam ewc_rsp_t    NAK   = '{8'h00, 1'b0, 1'b0};

    logic       core_clk;
    logic       reset_n;
    logic       cmd_valid;
    ewc_cmd_t   cmd;
    logic       cmd_ready;
    logic       rsp_valid;
    ewc_rsp_t   rsp;
    logic       scl;
    logic       sda_out;
    logic       sda_oe_n;
    logic       dev_oe_n;
    logic [7:0] rd_byte;
    logic [7:0] rx_byte;
    logic [7:0] addr;
    wire        sda_w;
    ewc_rsp_t   exp_q[$];
    ewc_rsp_t   msk_q[$];
    ewc_rsp_t   e;
    ewc_rsp_t   m;
    int         n_mismatch = 0;
    int         cmp_count = 0;
    integer     seed = 32'h9f227abc;

    // open drain data line with pull-up
    assign sda_w = (dev_oe_n === 1'b0) ? 1'b0 :
                   ((sda_oe_n === 1'b0) ? sda_out : 1'b1);

    ewc_host #(.POWER_UP_WAIT_CYCLES(PUW)) dut (
        .i_core_clk  (core_clk),
        .i_reset_n   (reset_n),
        .i_cmd_valid (cmd_valid),
        .i_cmd       (cmd),
        .o_cmd_ready (cmd_ready),
        .o_rsp_valid (rsp_valid),
        .o_rsp       (rsp),
        .o_scl       (scl),
        .i_scl       (scl),
        .i_sda       (sda_w),
        .o_sda       (sda_out),
        .o_sda_oe_n  (sda_oe_n)
    );

    ewc_eeprom_model #(.HW_ADDR(HW)) eeprom (
        .i_reset_n  (reset_n),
        .i_scl      (scl),
        .i_sda      (sda_w),
        .i_rd_byte  (rd_byte),
        .o_sda_oe_n (dev_oe_n),
        .o_rx_byte  (rx_byte)
    );

    // ------------------------------------------------------------------
    // checking and ending
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // one command: note the answer, hold until taken, time the whole run
    task automatic send(input ewc_cmd_kind_t k, input logic [7:0] d,
                        input logic nk, input ewc_rsp_t ex,
                        input ewc_rsp_t mk, input int unsigned lat);
        int unsigned n;
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd = '{kind: k, data: d, nack: nk};
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 40000) begin
            @(negedge core_clk);
            n++;
        end
        chk("latency", 32'(n), 32'(lat));
    endtask

    // answers are compared in arrival order
    always @(negedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("rsp_extra", 32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                chk("rsp", 32'(rsp & m), 32'(e & m));
            end
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // run is near 82k cycles; the limit leaves margin
    initial begin
        repeat (95000) @(posedge core_clk);
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int unsigned n;
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        rd_byte = 8'($random(seed));
        repeat (3) @(negedge core_clk);
        chk("scl_idle", 32'(scl), 32'h1);
        chk("sda_idle", 32'(sda_oe_n), 32'h1);
        reset_n = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(negedge core_clk);
            n++;
        end
        chk("power_up", 32'(n), 32'(PUW));
        send(CMD_STOP, 8'h00, 1'b0, '{8'h00, 1'b0, 1'b1}, ERR_M, 1);
        send(CMD_START, 8'h00, 1'b0, OK, ACK_M, 4 * Q_CYC + 1);
        addr = {4'hA, HW, 1'b1};
        send(CMD_WRITE, addr, 1'b0, OK, ACK_M, 36 * Q_CYC + 1);
        chk("rx_byte", 32'(rx_byte), 32'(addr));
        // host acks the first byte, so the device goes on with the next
        send(CMD_READ, 8'h00, 1'b0, '{rd_byte, 1'b1, 1'b0}, ALL_M,
             36 * Q_CYC + 1);
        send(CMD_READ, 8'h00, 1'b1, '{rd_byte, 1'b0, 1'b0}, ALL_M,
             36 * Q_CYC + 1);
        send(CMD_STOP, 8'h00, 1'b0, OK, ACK_M, 4 * Q_CYC + 1);
        send(CMD_START, 8'h00, 1'b0, OK, ACK_M, 4 * Q_CYC + 1);
        addr = {4'hA, 3'($random(seed)) | 3'h1, 1'b0};
        send(CMD_WRITE, addr, 1'b0, NAK, ACK_M, 36 * Q_CYC + 1);
        send(CMD_STOP, 8'h00, 1'b0, OK, ACK_M, 4 * Q_CYC + 1);
        send(CMD_RECOVER, 8'h00, 1'b0, OK, ACK_M, 3 * Q_CYC + 1);
        chk("pending", 32'(exp_q.size()), 32'h0);
        finish_test();
    end
endmodule // ewc_host_tb

`default_nettype wire
